// [verilog/cwd_config_decoder.sv]
// Configuration word holder, programmer port and option decoder
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps

// ==========================================================
// What this block does
// - two 14-bit words at 8007h and 8008h
// - blank, erased and unimplemented bits read one
// - bit 13 enables clock monitor and switchover
// - word one bit 12 enables two-speed switchover
// - clock-out bit ignored in crystal modes
// - brown-out field selects four modes
// - data-protect bit zero enables EEPROM protection
// - program protect blocks external writes, reads zero
// - reset pin select ignored under low-voltage programming
// - power-up timer enabled when bit five zero
// - watchdog field selects four modes
// - oscillator field selects eight clock sources
// - bulk erase clears flash, EEPROM, configuration
// - low-voltage enable cannot clear in LV entry
// - debug bit zero dedicates programming pins
// - word two bit 11 zero enables low-power BOR
// - trip bit one low threshold, zero high
// - stack fault reset when bit nine set
// - bit eight enables four-times PLL
// - bit five zero puts regulator cap on pin
// - 2K variant write-protect ranges by field
// - 4K variant write-protect ranges by field
// - data protect blocks external EEPROM access only
module cwd_config_decoder #(
    parameter bit LARGE_FLASH = 1'b1
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // Nonvolatile words presented by the flash array
    input  wire logic [13:0]           nvWordOne,
    input  wire logic [13:0]           nvWordTwo,
    // Programming mode is active
    input  wire logic                  progModeActive,
    // Classic Wishbone slave
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_we_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       wb_err_o,
    // Decoded options
    output cwd_pkg::cwd_opts_type      options,
    // Protection gating for external access paths
    output logic                       extProgWriteBlock,
    output logic                       extProgReadZero,
    output logic                       extEepromBlock,
    // Bulk erase pulse to program flash and EEPROM
    output logic                       bulkErasePulse
);

    // ==========================================================
    // Elaboration checks
    // Field positions assume the fourteen-bit word
    if (cwd_pkg::WORD_W != 14) begin : g_width_check
        $error("word width must be fourteen");
    end

    // ==========================================================
    // State
    logic [13:0] wordOne_ff, nxt_wordOne;
    logic [13:0] wordTwo_ff, nxt_wordTwo;
    logic        loaded_ff, nxt_loaded;
    logic        progSync1_ff, progSync_ff;
    logic        progMode_ff, nxt_progMode;
    logic [4:0]  ctrl_ff, nxt_ctrl;
    logic [13:0] progData_ff, nxt_progData;
    logic        refused_ff, nxt_refused;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        ack_ff, nxt_ack;
    logic        err_ff, nxt_err;
    logic        erase_ff, nxt_erase;
    cwd_pkg::cwd_opts_type opts_ff, nxt_opts;
    logic        blkW_ff, nxt_blkW;
    logic        rdZero_ff, nxt_rdZero;
    logic        blkE_ff, nxt_blkE;

    // ==========================================================
    // Synchroniser
    // Pin-level mode flag from outside the clock domain
    // Only the second stage feeds logic
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            progSync1_ff <= 1'b0;
            progSync_ff  <= 1'b0;
        end else begin
            progSync1_ff <= progModeActive;
            progSync_ff  <= progSync1_ff;
        end
    end

    // ==========================================================
    // Word storage and programmer commands
    logic        busReq;
    logic        validAdr;
    logic [13:0] wrWord;
    logic [13:0] progValue;

    always_comb begin
        // Registered answer keeps ack off the address path
        busReq = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
        case (wb_adr_i)
            cwd_pkg::REG_WORD_ONE,
            cwd_pkg::REG_WORD_TWO,
            cwd_pkg::REG_PROG_CTRL,
            cwd_pkg::REG_PROG_DATA,
            cwd_pkg::REG_STATUS: validAdr = 1'b1;
            default:             validAdr = 1'b0;
        endcase
        nxt_wordOne = wordOne_ff;
        nxt_wordTwo = wordTwo_ff;
        nxt_loaded = 1'b1;
        nxt_progMode = progSync_ff;
        nxt_ctrl = ctrl_ff;
        nxt_progData = progData_ff;
        nxt_refused = refused_ff;
        nxt_erase = 1'b0;
        nxt_ack = 1'b0;
        nxt_err = 1'b0;
        nxt_rdata = 32'h0000_0000;
        wrWord = 14'h0000;
        progValue = 14'h0000;
        // capture words once after reset release
        if (!loaded_ff) begin
            nxt_wordOne = nvWordOne;
            nxt_wordTwo = nvWordTwo | cwd_pkg::WORD_TWO_UNIMPL;
        end
        if (busReq) begin
            nxt_ack = validAdr;
            nxt_err = !validAdr;
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == cwd_pkg::REG_PROG_CTRL) begin
                nxt_ctrl = wb_dat_i[4:0];
            end
            if (wb_we_i && wb_adr_i == cwd_pkg::REG_PROG_DATA) begin
                if (wb_sel_i[0]) begin
                    nxt_progData[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    nxt_progData[13:8] = wb_dat_i[13:8];
                end
            end
            if (!wb_we_i) begin
                case (wb_adr_i)
                    cwd_pkg::REG_WORD_ONE:  nxt_rdata = {18'h00000, wordOne_ff};
                    cwd_pkg::REG_WORD_TWO:  nxt_rdata = {18'h00000, wordTwo_ff};
                    cwd_pkg::REG_PROG_CTRL: nxt_rdata = {27'h0000000, ctrl_ff};
                    cwd_pkg::REG_PROG_DATA: nxt_rdata = {18'h00000, progData_ff};
                    cwd_pkg::REG_STATUS:    nxt_rdata = {29'h00000000, refused_ff, progMode_ff, loaded_ff};
                    default:                nxt_rdata = 32'h0000_0000;
                endcase
            end
        end
        // Programmer command executes one cycle after go is written
        if (ctrl_ff[cwd_pkg::CTL_GO]) begin
            // Go self-clears so a command runs once
            nxt_ctrl[cwd_pkg::CTL_GO] = 1'b0;
            if (!progMode_ff) begin
                nxt_refused = 1'b1;
            end else if (ctrl_ff[cwd_pkg::CTL_BULK]) begin
                // bulk erase restores every bit to blank
                // Protection lifts one cycle after the erase pulse
                nxt_wordOne = cwd_pkg::BLANK_WORD;
                nxt_wordTwo = cwd_pkg::BLANK_WORD;
                nxt_erase = 1'b1;
                nxt_refused = 1'b0;
            end else if (ctrl_ff[cwd_pkg::CTL_WRITE]) begin
                // Programming only clears bits
                wrWord = ctrl_ff[cwd_pkg::CTL_SEL_TWO] ? wordTwo_ff : wordOne_ff;
                wrWord = wrWord & progData_ff;
                nxt_refused = 1'b0;
                if (ctrl_ff[cwd_pkg::CTL_SEL_TWO]) begin
                    // low-voltage enable held while entered that way
                    // Refusal keeps the bit and flags status
                    if (ctrl_ff[cwd_pkg::CTL_LOW_VOLT_ENTRY] && !progData_ff[cwd_pkg::W2_LOW_VOLT]) begin
                        wrWord[cwd_pkg::W2_LOW_VOLT] = 1'b1;
                        nxt_refused = 1'b1;
                    end
                    nxt_wordTwo = wrWord | cwd_pkg::WORD_TWO_UNIMPL;
                end else begin
                    nxt_wordOne = wrWord;
                end
            end else begin
                progValue = ctrl_ff[cwd_pkg::CTL_SEL_TWO] ? wordTwo_ff : wordOne_ff;
                nxt_progData = progValue;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wordOne_ff  <= cwd_pkg::BLANK_WORD;
            wordTwo_ff  <= cwd_pkg::BLANK_WORD;
            loaded_ff   <= 1'b0;
            progMode_ff <= 1'b0;
            ctrl_ff     <= 5'h00;
            progData_ff <= cwd_pkg::BLANK_WORD;
            refused_ff  <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            ack_ff      <= 1'b0;
            err_ff      <= 1'b0;
            erase_ff    <= 1'b0;
        end else begin
            wordOne_ff  <= nxt_wordOne;
            wordTwo_ff  <= nxt_wordTwo;
            loaded_ff   <= nxt_loaded;
            progMode_ff <= nxt_progMode;
            ctrl_ff     <= nxt_ctrl;
            progData_ff <= nxt_progData;
            refused_ff  <= nxt_refused;
            rdata_ff    <= nxt_rdata;
            ack_ff      <= nxt_ack;
            err_ff      <= nxt_err;
            erase_ff    <= nxt_erase;
        end
    end

    // ==========================================================
    // Option decode
    logic       crystalMode;
    logic [2:0] oscField;

    always_comb begin
        // Options follow a word change one cycle later
        nxt_opts = opts_ff;
        oscField = wordOne_ff[cwd_pkg::W1_OSC_HI:0];
        crystalMode = (oscField == cwd_pkg::XTAL_LOW) ||
                      (oscField == cwd_pkg::XTAL_STD) ||
                      (oscField == cwd_pkg::XTAL_FAST);
        nxt_opts.clockMonitorEn = wordOne_ff[cwd_pkg::W1_FCM];
        nxt_opts.switchoverEn = wordOne_ff[cwd_pkg::W1_SWITCH] | wordOne_ff[cwd_pkg::W1_FCM];
        // crystal modes keep pin for oscillator
        nxt_opts.clockOutEn = !crystalMode && !wordOne_ff[cwd_pkg::W1_CKO];
        nxt_opts.oscPinIsIo = !crystalMode && wordOne_ff[cwd_pkg::W1_CKO];
        nxt_opts.brownoutMode = cwd_pkg::cwd_mode_type'(wordOne_ff[cwd_pkg::W1_BOR_HI:cwd_pkg::W1_BOR_LO]);
        nxt_opts.dataProtect = !wordOne_ff[cwd_pkg::W1_DATA_LOCK];
        nxt_opts.programProtect = !wordOne_ff[cwd_pkg::W1_PROG_LOCK];
        // low-voltage programming keeps reset pin active
        nxt_opts.resetPinActive = wordTwo_ff[cwd_pkg::W2_LOW_VOLT] | wordOne_ff[cwd_pkg::W1_RPS];
        nxt_opts.powerupTimerEn = !wordOne_ff[cwd_pkg::W1_PWRT];
        nxt_opts.watchdogMode = cwd_pkg::cwd_mode_type'(wordOne_ff[cwd_pkg::W1_WDT_HI:cwd_pkg::W1_WDT_LO]);
        nxt_opts.oscSelect = cwd_pkg::cwd_osc_type'(wordOne_ff[cwd_pkg::W1_OSC_HI:0]);
        nxt_opts.lowVoltProgEn = wordTwo_ff[cwd_pkg::W2_LOW_VOLT];
        nxt_opts.debuggerEn = !wordTwo_ff[cwd_pkg::W2_DBG];
        nxt_opts.lowPowerBorEn = !wordTwo_ff[cwd_pkg::W2_LPB];
        nxt_opts.borLowTrip = wordTwo_ff[cwd_pkg::W2_TRIP];
        nxt_opts.stackFaultReset = wordTwo_ff[cwd_pkg::W2_STK];
        nxt_opts.pll_enable = wordTwo_ff[cwd_pkg::W2_PLL];
        nxt_opts.regCapOnPin = !wordTwo_ff[cwd_pkg::W2_REG_CAP];
        nxt_opts.writeProtectAny = wordTwo_ff[cwd_pkg::W2_WRT_HI:0] != cwd_pkg::WRT_OFF;
        if (LARGE_FLASH) begin
            case (wordTwo_ff[cwd_pkg::W2_WRT_HI:0])
                2'h2:    nxt_opts.writeProtectTop = cwd_pkg::WP_TOP_512;
                2'h1:    nxt_opts.writeProtectTop = cwd_pkg::WP_TOP_2K;
                2'h0:    nxt_opts.writeProtectTop = cwd_pkg::WP_TOP_4K;
                default: nxt_opts.writeProtectTop = cwd_pkg::WP_TOP_NONE;
            endcase
        end else begin
            case (wordTwo_ff[cwd_pkg::W2_WRT_HI:0])
                2'h2:    nxt_opts.writeProtectTop = cwd_pkg::WP_TOP_512;
                2'h1:    nxt_opts.writeProtectTop = cwd_pkg::WP_TOP_1K;
                2'h0:    nxt_opts.writeProtectTop = cwd_pkg::WP_TOP_2K;
                default: nxt_opts.writeProtectTop = cwd_pkg::WP_TOP_NONE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        // All zero in reset, then decoded from the blank words until the words land
        if (!rst_n) begin
            opts_ff <= '0;
        end else begin
            opts_ff <= nxt_opts;
        end
    end

    // ==========================================================
    // Protection gating
    // Own group so the external paths can be
    // retimed without touching the options
    always_comb begin
        // external program path blocked, reads zero
        nxt_blkW = !wordOne_ff[cwd_pkg::W1_PROG_LOCK];
        nxt_rdZero = !wordOne_ff[cwd_pkg::W1_PROG_LOCK];
        // external EEPROM path blocked, CPU path untouched
        nxt_blkE = !wordOne_ff[cwd_pkg::W1_DATA_LOCK];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            blkW_ff   <= 1'b0;
            rdZero_ff <= 1'b0;
            blkE_ff   <= 1'b0;
        end else begin
            blkW_ff   <= nxt_blkW;
            rdZero_ff <= nxt_rdZero;
            blkE_ff   <= nxt_blkE;
        end
    end

    // ==========================================================
    // Outputs
    // Every output is a register, no logic after the flops
    assign wb_dat_o = rdata_ff;
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign options = opts_ff;
    assign extProgWriteBlock = blkW_ff;
    assign extProgReadZero = rdZero_ff;
    assign extEepromBlock = blkE_ff;
    assign bulkErasePulse = erase_ff;

endmodule : cwd_config_decoder

// [verilog/cwd_pkg.sv]
// Constants and carriers for the configuration word decoder
package cwd_pkg;

    // ==========================================================
    // Word layout
    localparam int WORD_W = 14;
    localparam logic [15:0] ADDR_WORD_ONE = 16'h8007;
    localparam logic [15:0] ADDR_WORD_TWO = 16'h8008;
    localparam logic [13:0] BLANK_WORD = 14'h3fff;
    // Unimplemented bits of word two read as one
    localparam logic [13:0] WORD_TWO_UNIMPL = 14'h00dc;

    // Word one fields
    localparam int W1_FCM = 13;
    localparam int W1_SWITCH = 12;
    localparam int W1_CKO = 11;
    localparam int W1_BOR_HI = 10;
    localparam int W1_BOR_LO = 9;
    localparam int W1_DATA_LOCK = 8;
    localparam int W1_PROG_LOCK = 7;
    localparam int W1_RPS = 6;
    localparam int W1_PWRT = 5;
    localparam int W1_WDT_HI = 4;
    localparam int W1_WDT_LO = 3;
    localparam int W1_OSC_HI = 2;
    // Word two fields
    localparam int W2_LOW_VOLT = 13;
    localparam int W2_DBG = 12;
    localparam int W2_LPB = 11;
    localparam int W2_TRIP = 10;
    localparam int W2_STK = 9;
    localparam int W2_PLL = 8;
    localparam int W2_REG_CAP = 5;
    localparam int W2_WRT_HI = 1;
    // Self-write protect tops; field value 3 protects nothing
    localparam logic [1:0]  WRT_OFF = 2'h3;
    localparam logic [11:0] WP_TOP_NONE = 12'h000;
    localparam logic [11:0] WP_TOP_512 = 12'h1ff;
    localparam logic [11:0] WP_TOP_1K = 12'h3ff;
    localparam logic [11:0] WP_TOP_2K = 12'h7ff;
    localparam logic [11:0] WP_TOP_4K = 12'hfff;

    // ==========================================================
    // Wishbone register map, byte addresses
    localparam logic [7:0] REG_WORD_ONE = 8'h00;
    localparam logic [7:0] REG_WORD_TWO = 8'h04;
    localparam logic [7:0] REG_PROG_CTRL = 8'h08;
    localparam logic [7:0] REG_PROG_DATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // Control bits
    localparam int CTL_GO = 0;
    localparam int CTL_WRITE = 1;
    localparam int CTL_SEL_TWO = 2;
    localparam int CTL_BULK = 3;
    localparam int CTL_LOW_VOLT_ENTRY = 4;

    localparam logic [2:0] XTAL_LOW = 3'h0;
    localparam logic [2:0] XTAL_STD = 3'h1;
    localparam logic [2:0] XTAL_FAST = 3'h2;

    typedef enum logic [1:0] {
        MODE_OFF  = 2'h0,
        MODE_SW   = 2'h1,
        MODE_WAKE = 2'h2,
        MODE_ON   = 2'h3
    } cwd_mode_type;

    typedef enum logic [2:0] {
        OSC_LOW_POWER_XTAL = 3'h0, OSC_STD_XTAL = 3'h1, OSC_HS_XTAL = 3'h2, OSC_EXT_RC = 3'h3,
        OSC_INTERNAL = 3'h4, OSC_EXT_LOW = 3'h5, OSC_EXT_MED = 3'h6, OSC_EXT_HIGH = 3'h7
    } cwd_osc_type;

    typedef struct packed {
        logic         clockMonitorEn;
        logic         switchoverEn;
        logic         clockOutEn;
        logic         oscPinIsIo;
        cwd_mode_type brownoutMode;
        logic         dataProtect;
        logic         programProtect;
        logic         resetPinActive;
        logic         powerupTimerEn;
        cwd_mode_type watchdogMode;
        cwd_osc_type  oscSelect;
        logic         lowVoltProgEn;
        logic         debuggerEn;
        logic         lowPowerBorEn;
        logic         borLowTrip;
        logic         stackFaultReset;
        logic         pll_enable;
        logic         regCapOnPin;
        logic [11:0]  writeProtectTop;
        logic         writeProtectAny;
    } cwd_opts_type;

endpackage : cwd_pkg

// [dv/cwd_nv_model.sv]
// Nonvolatile word array and programmer mode source facing the decoder
`timescale 1ns/1ps

module cwd_nv_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [13:0] presetOne,
    input  wire logic [13:0] presetTwo,
    input  wire logic        progReq,
    input  wire logic        bulkErasePulse,
    output logic      [13:0] nvWordOne,
    output logic      [13:0] nvWordTwo,
    output logic             progModeActive
);
    // ==========================================================
    // Array contents
    // Reloaded on every edge in reset, so preset changes land safely
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nvWordOne <= presetOne;
            nvWordTwo <= presetTwo;
        end
        else if (bulkErasePulse) begin
            nvWordOne <= 14'h3fff;
            nvWordTwo <= 14'h3fff;
        end
    end
    assign progModeActive = progReq;
endmodule : cwd_nv_model

// [dv/cwd_config_decoder_properties.sv]
// Bus timing and option decode properties of the decoder
`timescale 1ns/1ps

module cwd_config_decoder_properties (
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire logic [7:0]            wb_adr_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_ack_o,
    input wire logic                  wb_err_o,
    input wire cwd_pkg::cwd_opts_type options,
    input wire logic                  extProgWriteBlock,
    input wire logic                  extProgReadZero,
    input wire logic                  extEepromBlock,
    input wire logic                  bulkErasePulse
);
    logic [2:0] quiet_ff;
    logic [2:0] nxt_quiet;
    logic       req;
    // ==========================================================
    // Idle counter: options may only move shortly after bus traffic
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    always_comb begin
        nxt_quiet = quiet_ff;
        if (wb_cyc_i) nxt_quiet = 3'h0;
        else if (quiet_ff != 3'h4) nxt_quiet = quiet_ff + 3'h1;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) quiet_ff <= 3'h0;
        else quiet_ff <= nxt_quiet;
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_answer; req |=> wb_ack_o ^ wb_err_o; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_pulse; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o; endproperty
    a_pulse: assert property (p_pulse) else $error("answer held too long");
    property p_unmap; req && !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}) |=> wb_err_o; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped address not refused");
    property p_fcm; options.clockMonitorEn |-> options.switchoverEn; endproperty
    a_fcm: assert property (p_fcm) else $error("monitor without switchover");
    property p_cko; options.oscSelect inside {3'h0, 3'h1, 3'h2} |-> !options.clockOutEn; endproperty
    a_cko: assert property (p_cko) else $error("clock out in crystal mode");
    property p_lvp; options.lowVoltProgEn |-> options.resetPinActive; endproperty
    a_lvp: assert property (p_lvp) else $error("reset pin not forced");
    property p_cp; $stable(options) && $stable(extProgWriteBlock) |->
        extProgWriteBlock == options.programProtect && extProgReadZero == extProgWriteBlock; endproperty
    a_cp: assert property (p_cp) else $error("program protect mismatch");
    property p_cpd; $stable(options) && $stable(extEepromBlock) |-> extEepromBlock == options.dataProtect; endproperty
    a_cpd: assert property (p_cpd) else $error("eeprom protect mismatch");
    property p_erase; bulkErasePulse |=> !bulkErasePulse; endproperty
    a_erase: assert property (p_erase) else $error("erase pulse too long");
    property p_static; quiet_ff == 3'h4 |-> $stable(options); endproperty
    a_static: assert property (p_static) else $error("options moved while idle");
endmodule : cwd_config_decoder_properties

bind cwd_config_decoder cwd_config_decoder_properties u_props (.clk_sys, .rst_n, .wb_adr_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_err_o, .options, .extProgWriteBlock, .extProgReadZero, .extEepromBlock,
    .bulkErasePulse);

// [dv/test_config_word_decoder.sv]
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ps

module test_config_word_decoder;
    logic                  clk_sys = 1'b0;
    logic                  rst_n = 1'b0;
    logic [13:0]           presetOne = 14'h3fff, presetTwo = 14'h3fff, nvWordOne, nvWordTwo;
    logic                  progReq = 1'b0, progModeActive, wb_ack_o, wb_err_o, e;
    logic [7:0]            wb_adr_i = 8'h00;
    logic [31:0]           wb_dat_i = 32'h0, wb_dat_o, q;
    logic [3:0]            wb_sel_i = 4'h0;
    logic                  wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    cwd_pkg::cwd_opts_type options, optsSmall;
    logic                  extProgWriteBlock, extProgReadZero, extEepromBlock, bulkErasePulse;
    int                    errTotal = 0, checkCount = 0, pulseCnt = 0;

    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (bulkErasePulse === 1'b1) pulseCnt++;

    cwd_config_decoder DUT (.clk_sys, .rst_n, .nvWordOne, .nvWordTwo, .progModeActive, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .options,
        .extProgWriteBlock, .extProgReadZero, .extEepromBlock, .bulkErasePulse);
    cwd_nv_model u_nv (.clk_sys, .rst_n, .presetOne, .presetTwo, .progReq, .bulkErasePulse,
        .nvWordOne, .nvWordTwo, .progModeActive);
    cwd_config_decoder #(.LARGE_FLASH(1'b0)) DUT_SMALL (.clk_sys, .rst_n, .nvWordOne, .nvWordTwo,
        .progModeActive, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i(1'b0), .wb_stb_i(1'b0),
        .wb_dat_o(), .wb_ack_o(), .wb_err_o(), .options(optsSmall), .extProgWriteBlock(),
        .extProgReadZero(), .extEepromBlock(), .bulkErasePulse());

    // ==========================================================
    // Helpers
    function automatic cwd_pkg::cwd_opts_type expOpts(input logic [13:0] a, input logic [13:0] b);
        logic [11:0] top;
        top = (b[1:0] == 2'h3) ? 12'h000 : (b[1:0] == 2'h2) ? 12'h1ff : (b[1:0] == 2'h1) ? 12'h7ff : 12'hfff;
        return cwd_pkg::cwd_opts_type'({a[13], a[13] | a[12], (a[2:0] > 3'h2) & ~a[11], (a[2:0] > 3'h2) & a[11],
            a[10:9], ~a[8],
            ~a[7], b[13] | a[6], ~a[5], a[4:3], a[2:0], b[13], ~b[12], ~b[11], b[10], b[9], b[8], ~b[5], top,
            b[1:0] != 2'h3});
    endfunction : expOpts

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chkOpts(input cwd_pkg::cwd_opts_type got, input cwd_pkg::cwd_opts_type exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkOpts

    // Classic cycle, held until ack or err is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) errTotal++;
    endtask : wb

    task automatic doReset();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask : doReset

    task automatic wrapUp();
        $display("checks=%0d errors=%0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrapUp

    // ==========================================================
    // Scenarios
    task automatic testDecode();
        logic [2:0]  k;
        logic [13:0] a, b;
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            a = {k[0], k[1], k[2], k[1:0], k[2], k[0], k[1], k[2], k[1:0], k};
            b = {k[2], k[0], k[1], k[2], k[0], k[1], k[1:0], k[2], k, k[1:0]};
            presetOne <= a;
            presetTwo <= b;
            doReset();
            wb(cwd_pkg::REG_WORD_ONE, 1'b0, 32'h0);
            chk(q, {18'h0, a});
            wb(cwd_pkg::REG_WORD_TWO, 1'b0, 32'h0);
            chk(q, {18'h0, b | cwd_pkg::WORD_TWO_UNIMPL});
            chkOpts(options, expOpts(a, b | cwd_pkg::WORD_TWO_UNIMPL));
            chk({20'h0, optsSmall.writeProtectTop}, (b[1:0] == 2'h3) ? 32'h0 : (b[1:0] == 2'h2) ? 32'h1ff :
                (b[1:0] == 2'h1) ? 32'h3ff : 32'h7ff);
        end
    endtask : testDecode

    task automatic testBus();
        presetOne <= 14'h3fff;
        presetTwo <= 14'h3fff;
        doReset();
        wb(8'h14, 1'b0, 32'h0);
        chk({31'h0, e}, 32'h1);
        wb(cwd_pkg::REG_WORD_ONE, 1'b1, 32'h0);
        wb(cwd_pkg::REG_PROG_DATA, 1'b1, 32'h0);
        wb(cwd_pkg::REG_PROG_CTRL, 1'b1, 32'h3);
        wb(cwd_pkg::REG_STATUS, 1'b0, 32'h0);
        chk(q & 32'h5, 32'h5);
        wb(cwd_pkg::REG_WORD_ONE, 1'b0, 32'h0);
        chk(q, 32'h3fff);
    endtask : testBus

    task automatic testProgram();
        progReq <= 1'b1;
        repeat (4) @(posedge clk_sys);
        wb(cwd_pkg::REG_PROG_DATA, 1'b1, 32'h1fff);
        wb(cwd_pkg::REG_PROG_CTRL, 1'b1, 32'h17);
        wb(cwd_pkg::REG_STATUS, 1'b0, 32'h0);
        chk(q & 32'h6, 32'h6);
        wb(cwd_pkg::REG_WORD_TWO, 1'b0, 32'h0);
        chk(q, 32'h3fff);
        wb(cwd_pkg::REG_PROG_DATA, 1'b1, 32'h3e7f);
        wb(cwd_pkg::REG_PROG_CTRL, 1'b1, 32'h3);
        wb(cwd_pkg::REG_STATUS, 1'b0, 32'h0);
        chk(q & 32'h4, 32'h0);
        wb(cwd_pkg::REG_WORD_ONE, 1'b0, 32'h0);
        chk(q, 32'h3e7f);
        repeat (2) @(posedge clk_sys);
        chk({29'h0, extProgWriteBlock, extProgReadZero, extEepromBlock}, 32'h7);
        chkOpts(options, expOpts(14'h3e7f, 14'h3fff));
        wb(cwd_pkg::REG_PROG_CTRL, 1'b1, 32'h5);
        wb(cwd_pkg::REG_PROG_DATA, 1'b0, 32'h0);
        chk(q, 32'h3fff);
        wb(cwd_pkg::REG_PROG_CTRL, 1'b1, 32'h9);
        repeat (3) @(posedge clk_sys);
        chk(32'(pulseCnt), 32'h1);
        wb(cwd_pkg::REG_WORD_ONE, 1'b0, 32'h0);
        chk(q, 32'h3fff);
        chk({29'h0, extProgWriteBlock, extProgReadZero, extEepromBlock}, 32'h0);
    endtask : testProgram

    initial begin
        testDecode();
        testBus();
        testProgram();
        wrapUp();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        errTotal++;
        wrapUp();
    end
endmodule : test_config_word_decoder
